// ---- hdl/flash_fault_prot.v ----
`timescale 1ns/100ps
`include "flash_prot_defines.vh"

// What this block does
// [R1] Double-fault flag bit 1 sets on uncorrectable read error or read of busy block.
// [R2] Writing one clears the double-fault flag; writing zero leaves it.
// [R3] Single-fault flag bit 0 sets on corrected error or busy read unless ignored.
// [R4] Writing one clears the single-fault flag; writing zero leaves it.
// [R5] Protection register loads from the stored protection byte during reset sequence.
// [R6] Double fault on that load clears operation enable and sets all other bits.
// [R7] Program or erase touching protected area is refused and sets violation flag.
// [R8] Block erase refused whenever any sector of the block is protected.
// [R9] Bit 7 clear: windows are unprotected; bit 7 set: windows are protected.
// [R10] Bit 5 zero enables the high window ending at top of array.
// [R11] High size field picks 2, 4, 8 or 16 Kbyte high window.
// [R12] High size field writable only while high disable bit is set.
// [R13] Bit 2 zero enables the low window starting at array low base.
// [R14] Low size field picks 1, 2, 4 or 8 Kbyte low window.
// [R15] Low size field writable only while low disable bit is set.
// [R16] Enable and disable bits combine into none, full, high, low or both windows.
// [R17] Protection writes to a scenario not permitted from the current one are ignored.
// [R18] Protection register always reads the scenario in force.
// [R19] Software should leave reserved nonvolatile bit 6 erased.
// [R20] Interrupt requested when a fault flag and its enable are both set.
// [R21] Scenario index is the operation enable and both disable bits, high first.
module flash_fault_prot (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire        clk_en,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [7:0]  s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	output reg  [1:0]  s_axi_bresp,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	input  wire [7:0]  s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	input  wire        prot_load,
	input  wire [7:0]  prot_load_byte,
	input  wire        prot_load_double_fault,
	input  wire        array_read,
	input  wire        read_single_error,
	input  wire        read_double_error,
	input  wire        read_block_busy,
	input  wire        check_valid,
	input  wire [22:0] check_addr,
	input  wire        check_block_erase,
	output reg         check_done,
	output reg         check_refused,
	output reg  [7:0]  program_flash_protection,
	output reg         protection_violation_flag,
	output reg         fault_irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Registers and internal state

	reg        ignore_single_fault;
	reg        double_fault_irq_enable;
	reg        single_fault_irq_enable;
	reg        double_fault_flag;
	reg        single_fault_flag;

	wire [5:0] wr_idx;
	wire [5:0] rd_idx;
	wire       wr_fire;
	wire       rd_fire;
	wire       wr_lane;
	wire [7:0] wbyte;
	reg  [7:0] next_prot;
	reg        next_dff;
	reg        next_sff;
	reg        next_pvf;
	reg  [7:0] rd_byte;
	reg        rd_hit;
	reg        chk_prot;

	assign wr_idx  = s_axi_awaddr[7:2];
	assign rd_idx  = s_axi_araddr[7:2];
	assign wr_fire = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
	assign rd_fire = s_axi_arvalid & s_axi_arready;
	assign wr_lane = s_axi_wstrb[0];
	assign wbyte   = s_axi_wdata[7:0];

	////////////////////////////////////////////////////////////////////////////////
	// Functions

	function [2:0] scenario;
		input [7:0] p;
		begin
			scenario = {p[`BIT_OP_ENABLE], p[`BIT_HIGH_DIS], p[`BIT_LOW_DIS]}; // [R21]
		end
	endfunction

	function allowed;
		input [2:0] from;
		input [2:0] to;
		reg   [7:0] mask;
		begin
			case (from)
				3'h0: mask = `ALLOW_FROM_0;
				3'h1: mask = `ALLOW_FROM_1;
				3'h2: mask = `ALLOW_FROM_2;
				3'h3: mask = `ALLOW_FROM_3;
				3'h4: mask = `ALLOW_FROM_4;
				3'h5: mask = `ALLOW_FROM_5;
				3'h6: mask = `ALLOW_FROM_6;
				default: mask = `ALLOW_FROM_7;
			endcase
			allowed = mask[to]; // [R17]
		end
	endfunction

	function [22:0] high_start;
		input [1:0] sz;
		begin
			case (sz)
				2'h0: high_start = `HIGH_START_00; // [R11]
				2'h1: high_start = `HIGH_START_01;
				2'h2: high_start = `HIGH_START_10;
				default: high_start = `HIGH_START_11;
			endcase
		end
	endfunction

	function [22:0] low_end;
		input [1:0] sz;
		begin
			case (sz)
				2'h0: low_end = `LOW_END_00; // [R14]
				2'h1: low_end = `LOW_END_01;
				2'h2: low_end = `LOW_END_10;
				default: low_end = `LOW_END_11;
			endcase
		end
	endfunction

	function is_protected;
		input [7:0]  p;
		input [22:0] a;
		reg          in_high;
		reg          in_low;
		reg          in_win;
		begin
			in_high = !p[`BIT_HIGH_DIS] && a >= high_start(p[4:3]) && a <= `ARRAY_TOP; // [R10]
			in_low  = !p[`BIT_LOW_DIS] && a >= `LOW_START && a <= low_end(p[1:0]); // [R13]
			in_win  = in_high | in_low;
			if (p[`BIT_OP_ENABLE]) begin
				is_protected = in_win; // [R9] [R16]
			end else begin
				is_protected = !in_win; // [R9] [R16]
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Next values

	always @* begin
		next_prot = program_flash_protection;
		if (wr_fire && wr_lane && wr_idx == `IDX_PROTECTION) begin
			next_prot[`BIT_OP_ENABLE] = wbyte[`BIT_OP_ENABLE];
			next_prot[`BIT_HIGH_DIS]  = wbyte[`BIT_HIGH_DIS];
			next_prot[`BIT_LOW_DIS]   = wbyte[`BIT_LOW_DIS];
			if (program_flash_protection[`BIT_HIGH_DIS]) begin
				next_prot[4:3] = wbyte[4:3]; // [R12]
			end
			if (program_flash_protection[`BIT_LOW_DIS]) begin
				next_prot[1:0] = wbyte[1:0]; // [R15]
			end
			if (!allowed(scenario(program_flash_protection), scenario(next_prot))) begin
				next_prot = program_flash_protection; // [R17] [R18]
			end
		end
		if (prot_load) begin
			if (prot_load_double_fault) begin
				next_prot = `PROT_FULL; // [R6]
			end else begin
				next_prot = prot_load_byte; // [R5]
			end
		end
	end

	always @* begin
		next_dff = double_fault_flag;
		next_sff = single_fault_flag;
		next_pvf = protection_violation_flag;
		if (wr_fire && wr_lane && wr_idx == `IDX_FAULT_STATUS) begin
			if (wbyte[`BIT_DOUBLE_FAULT]) begin
				next_dff = 1'b0; // [R2]
			end
			if (wbyte[`BIT_SINGLE_FAULT]) begin
				next_sff = 1'b0; // [R4]
			end
		end
		if (wr_fire && wr_lane && wr_idx == `IDX_STATUS && wbyte[`BIT_PVIOL]) begin
			next_pvf = 1'b0;
		end
		if (array_read && (read_double_error || read_block_busy)) begin
			next_dff = 1'b1; // [R1]
		end
		if (array_read && !ignore_single_fault && (read_single_error || read_block_busy)) begin
			next_sff = 1'b1; // [R3]
		end
		if (check_valid && chk_prot) begin
			next_pvf = 1'b1; // [R7]
		end
	end

	always @* begin
		if (check_block_erase) begin
			chk_prot = scenario(program_flash_protection) != 3'h7; // [R8]
		end else begin
			chk_prot = is_protected(program_flash_protection, check_addr); // [R7]
		end
	end

	always @* begin
		rd_hit  = 1'b1;
		rd_byte = `BYTE_ZERO;
		case (rd_idx)
			`IDX_CONFIG: begin
				rd_byte[`BIT_IGNORE_SF] = ignore_single_fault;
			end
			`IDX_IRQ_CONFIG: begin
				rd_byte[`BIT_DOUBLE_FAULT] = double_fault_irq_enable;
				rd_byte[`BIT_SINGLE_FAULT] = single_fault_irq_enable;
			end
			`IDX_STATUS: begin
				rd_byte[`BIT_PVIOL] = protection_violation_flag;
			end
			`IDX_FAULT_STATUS: begin
				rd_byte[`BIT_DOUBLE_FAULT] = double_fault_flag;
				rd_byte[`BIT_SINGLE_FAULT] = single_fault_flag;
			end
			`IDX_PROTECTION: begin
				rd_byte = program_flash_protection; // [R18]
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register state

	always @(posedge aclk) begin
		if (!aresetn) begin
			ignore_single_fault       <= 1'b0;
			double_fault_irq_enable   <= 1'b0;
			single_fault_irq_enable   <= 1'b0;
			double_fault_flag         <= 1'b0;
			single_fault_flag         <= 1'b0;
			protection_violation_flag <= 1'b0;
			program_flash_protection  <= `PROT_FULL;
			fault_irq                 <= 1'b0;
			check_done                <= 1'b0;
			check_refused             <= 1'b0;
		end else if (clk_en) begin
			if (wr_fire && wr_lane && wr_idx == `IDX_CONFIG) begin
				ignore_single_fault <= wbyte[`BIT_IGNORE_SF];
			end
			if (wr_fire && wr_lane && wr_idx == `IDX_IRQ_CONFIG) begin
				double_fault_irq_enable <= wbyte[`BIT_DOUBLE_FAULT];
				single_fault_irq_enable <= wbyte[`BIT_SINGLE_FAULT];
			end
			double_fault_flag         <= next_dff;
			single_fault_flag         <= next_sff;
			protection_violation_flag <= next_pvf;
			program_flash_protection  <= next_prot;
			fault_irq                 <= (next_dff & double_fault_irq_enable) |
				(next_sff & single_fault_irq_enable); // [R20]
			check_done                <= check_valid;
			check_refused             <= check_valid & chk_prot; // [R7] [R8]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else if (clk_en) begin
			if (wr_fire) begin
				s_axi_awready <= 1'b0;
				s_axi_wready  <= 1'b0;
				s_axi_bvalid  <= 1'b1;
				case (wr_idx)
					`IDX_CONFIG, `IDX_IRQ_CONFIG, `IDX_STATUS, `IDX_FAULT_STATUS, `IDX_PROTECTION: begin
						s_axi_bresp <= `RESP_OKAY;
					end
					default: begin
						s_axi_bresp <= `RESP_SLVERR;
					end
				endcase
			end else if (s_axi_bvalid) begin
				if (s_axi_bready) begin
					s_axi_bvalid <= 1'b0;
				end
			end else if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready) begin
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RESP_OKAY;
		end else if (clk_en) begin
			if (rd_fire) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= {24'h00_0000, rd_byte};
				s_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rvalid) begin
				if (s_axi_rready) begin
					s_axi_rvalid <= 1'b0;
				end
			end else if (s_axi_arvalid && !s_axi_arready) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule // flash_fault_prot

// ---- hdl/flash_prot_defines.vh ----
`ifndef FLASH_PROT_DEFINES_VH
`define FLASH_PROT_DEFINES_VH

// Register indices, byte address is four times the index
`define IDX_CONFIG        6'h04
`define IDX_IRQ_CONFIG    6'h05
`define IDX_STATUS        6'h06
`define IDX_FAULT_STATUS  6'h07
`define IDX_PROTECTION    6'h08

// Field positions
`define BIT_IGNORE_SF     0
`define BIT_SINGLE_FAULT  0
`define BIT_DOUBLE_FAULT  1
`define BIT_PVIOL         4
`define BIT_OP_ENABLE     7
`define BIT_RNV           6
`define BIT_HIGH_DIS      5
`define BIT_LOW_DIS       2

// Reset values
`define PROT_FULL         8'h7f
`define BYTE_ZERO         8'h00

// AXI responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// Address windows of the program array
`define ARRAY_TOP         23'h7f_ffff
`define HIGH_START_00     23'h7f_f800
`define HIGH_START_01     23'h7f_f000
`define HIGH_START_10     23'h7f_e000
`define HIGH_START_11     23'h7f_c000
`define LOW_START         23'h7f_8000
`define LOW_END_00        23'h7f_83ff
`define LOW_END_01        23'h7f_87ff
`define LOW_END_10        23'h7f_8fff
`define LOW_END_11        23'h7f_9fff

// Permitted target scenarios, one mask per source scenario
`define ALLOW_FROM_0      8'h0f
`define ALLOW_FROM_1      8'h0a
`define ALLOW_FROM_2      8'h0c
`define ALLOW_FROM_3      8'h08
`define ALLOW_FROM_4      8'h18
`define ALLOW_FROM_5      8'h3c
`define ALLOW_FROM_6      8'h5a
`define ALLOW_FROM_7      8'hff

`endif

// ---- sim/flash_fault_prot_props.sv ----
`timescale 1ns/100ps
module flash_fault_prot_props (
	input wire        aclk,
	input wire        aresetn,
	input wire        prot_load,
	input wire [7:0]  prot_load_byte,
	input wire        prot_load_double_fault,
	input wire        check_valid,
	input wire        check_block_erase,
	input wire        check_done,
	input wire        check_refused,
	input wire        protection_violation_flag,
	input wire [7:0]  program_flash_protection,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire [7:0] p    = program_flash_protection;
	wire       hold = !prot_load && !(s_axi_awvalid && s_axi_awready);
	////////////////////////////////////////////////////////////////
	check_done_a: assert property (check_valid |=> check_done)
		else $error("check request not answered");
	check_idle_a: assert property (!check_valid |=> !check_done)
		else $error("check answer without request");
	viol_set_a: assert property (check_done && check_refused |-> protection_violation_flag)
		else $error("refusal without violation flag");
	erase_refuse_a: assert property (check_valid && check_block_erase && !(p[7] && p[5] && p[2]) |=> check_refused)
		else $error("block erase accepted while protected");
	load_byte_a: assert property (prot_load && !prot_load_double_fault |=> p == $past(prot_load_byte))
		else $error("protection byte not loaded");
	load_fault_a: assert property (prot_load && prot_load_double_fault |=> p == 8'h7f)
		else $error("faulty load not fully protected");
	prot_hold_a: assert property (hold |=> $stable(p))
		else $error("protection changed without cause");
	high_size_a: assert property (!prot_load && !p[5] |=> p[4:3] == $past(p[4:3]))
		else $error("high size written while locked");
	low_size_a: assert property (!prot_load && !p[2] |=> p[1:0] == $past(p[1:0]))
		else $error("low size written while locked");
	full_sticky_a: assert property (!prot_load && !p[7] && p[5] && p[2] |=> !p[7] && p[5] && p[2])
		else $error("left full protection");
	rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
endmodule // flash_fault_prot_props
bind flash_fault_prot flash_fault_prot_props u_props (.*);

// ---- sim/testbench.sv ----
`timescale 1ns/100ps
module testbench;
	reg         aclk, aresetn, clk_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	reg         prot_load, prot_load_double_fault, array_read, read_single_error, read_double_error;
	reg         read_block_busy, check_valid, check_block_erase;
	reg  [7:0]  s_axi_awaddr, s_axi_araddr, prot_load_byte, p, w, ig, en, d;
	reg  [2:0]  s_axi_awprot, s_axi_arprot, r;
	reg  [31:0] s_axi_wdata, rd_data;
	reg  [3:0]  s_axi_wstrb;
	reg  [22:0] check_addr, a;
	reg  [1:0]  rsp, mf;
	reg         e;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire        check_done, check_refused, protection_violation_flag, fault_irq;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [7:0]  program_flash_protection;
	integer     mismatches = 0, n_compared = 0, f, t;
	localparam [63:0] ALLOW = 64'hff5a_3c18_080c_0a0f;
	flash_fault_prot uut (.*);
	////////////////////////////////////////////////////////////////
	task end_of_test;
		if (mismatches == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wr(input [7:0] ad, input [7:0] dt);
		@(posedge aclk);
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_awaddr <= ad;
		s_axi_wdata <= {24'h00_0000, dt};
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 0;
		rsp = s_axi_bresp;
	endtask
	task rd(input [7:0] ad);
		@(posedge aclk);
		s_axi_arvalid <= 1;
		s_axi_araddr <= ad;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 0;
		rd_data = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask
	task load(input [7:0] b, input df);
		@(posedge aclk);
		prot_load <= 1;
		prot_load_byte <= b;
		prot_load_double_fault <= df;
		@(posedge aclk);
		prot_load <= 0;
	endtask
	function [2:0] scn(input [7:0] v);
		scn = {v[7], v[5], v[2]};
	endfunction
	function [7:0] exp_wr(input [7:0] o, input [7:0] n);
		reg [7:0] m;
		m = {n[7], o[6], n[5], o[5] ? n[4:3] : o[4:3], n[2], o[2] ? n[1:0] : o[1:0]};
		exp_wr = ALLOW[scn(o) * 8 + scn(m)] ? m : o;
	endfunction
	function refused(input [7:0] v, input [22:0] ad, input er);
		reg hi, lo, win;
		hi = {1'b0, ad} >= 24'h80_0000 - (24'h00_0800 << v[4:3]);
		lo = ad >= 23'h7f_8000 && ad < 23'h7f_8000 + (23'h00_0400 << v[1:0]);
		win = (!v[5] && hi) || (!v[2] && lo);
		refused = er ? scn(v) != 3'h7 : (v[7] ? win : !win);
	endfunction
	////////////////////////////////////////////////////////////////
	initial begin
		aclk = 0;
		forever #50 aclk = ~aclk;
	end
	initial begin
		#(100 * 60000);
		mismatches++;
		end_of_test;
	end
	initial begin
		{aresetn, clk_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, prot_load} = 0;
		{prot_load_double_fault, array_read, read_single_error, read_double_error, read_block_busy} = 0;
		{check_valid, check_block_erase, s_axi_awaddr, s_axi_araddr, prot_load_byte, s_axi_awprot} = 0;
		{s_axi_arprot, s_axi_wdata, check_addr, mf} = 0;
		clk_en = 1;
		s_axi_wstrb = 4'hf;
		void'($urandom(13));
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		rd(8'h20);
		chk("reset protection", rd_data, 32'h0000_007f);
		load(8'hff, 1);
		rd(8'h20);
		chk("faulty load", rd_data, 32'h0000_007f);
		for (f = 0; f < 8; f++) for (t = 0; t < 8; t++) begin
			p = $urandom;
			p[6] = 1'b1;
			{p[7], p[5], p[2]} = f;
			w = $urandom;
			{w[7], w[5], w[2]} = t;
			load(p, 0);
			wr(8'h20, w);
			rd(8'h20);
			chk("protection read", rd_data, {24'h00_0000, exp_wr(p, w)});
			chk("protection port", program_flash_protection, exp_wr(p, w));
		end
		repeat (200) begin
			p = $urandom;
			p[6] = 1'b1;
			a = 23'h7f_0000 | ($urandom % 65536);
			e = ($urandom % 4) == 0;
			load(p, 0);
			wr(8'h18, 8'h10);
			@(posedge aclk);
			check_valid <= 1;
			check_addr <= a;
			check_block_erase <= e;
			@(posedge aclk);
			check_valid <= 0;
			@(posedge aclk);
			chk("check done", check_done, 1);
			chk("check refused", check_refused, refused(p, a, e));
			chk("violation flag", protection_violation_flag, refused(p, a, e));
		end
		repeat (40) begin
			ig = $urandom;
			en = $urandom;
			r = $urandom;
			wr(8'h10, ig);
			wr(8'h14, en);
			@(posedge aclk);
			array_read <= 1;
			{read_single_error, read_double_error, read_block_busy} <= r;
			@(posedge aclk);
			array_read <= 0;
			mf = mf | {r[1] | r[0], !ig[0] & (r[2] | r[0])};
			rd(8'h1c);
			chk("fault flags", rd_data, {30'h0, mf});
			chk("fault irq", fault_irq, |(mf & en[1:0]));
			d = $urandom;
			wr(8'h1c, d);
			mf = mf & ~d[1:0];
			rd(8'h1c);
			chk("flags cleared", rd_data, {30'h0, mf});
			chk("irq cleared", fault_irq, |(mf & en[1:0]));
		end
		// Frozen clock enable must ignore a faulty array read
		@(posedge aclk);
		clk_en <= 0;
		array_read <= 1;
		{read_single_error, read_double_error, read_block_busy} <= 3'b111;
		repeat (2) @(posedge aclk);
		array_read <= 0;
		clk_en <= 1;
		rd(8'h1c);
		chk("frozen flags", rd_data, {30'h0, mf});
		rd(8'h30);
		chk("unmapped read", rsp, 2);
		wr(8'h30, 8'hff);
		chk("unmapped write", rsp, 2);
		end_of_test;
	end
endmodule // testbench
